// ---- verilog/dftm_pkg.sv ----
/*
 * shared constants and types of the set-point mode register link
 * assumes a 125 MHz system clock on both ends
 */
package dftm_pkg;
    // mode register addresses
    localparam logic [5:0] MA_CTL   = 6'h0D;
    localparam logic [5:0] MA_DQREF = 6'h0E;
    // training control and dq reference range bit positions
    localparam int BIT_TRAIN    = 0;
    localparam int BIT_PREAMBLE = 1;
    localparam int BIT_REFOUT   = 2;
    localparam int BIT_FASTREF  = 3;
    localparam int BIT_RATEOPT  = 4;
    localparam int BIT_MASKOFF  = 5;
    localparam int BIT_WRSEL = 6;
    localparam int BIT_OPSEL = 7;
    localparam int BIT_RANGE = 6;
    // values after reset
    localparam logic [7:0] CTL_RESET      = 8'h00;
    localparam logic [5:0] DQ_CODE_RESET  = 6'h1D;
    localparam logic       DQ_RANGE_RESET = 1'b1;
    localparam logic [5:0] DQ_CODE_MAX    = 6'h32;
    // refresh report codes
    localparam logic [2:0] RR_CODE_A = 3'h1;
    localparam logic [2:0] RR_CODE_B = 3'h2;
    localparam logic [2:0] RR_SUBST  = 3'h3;
    // timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CK_PERIOD_NS   = 64;
    localparam int CK_HALF_CYCLES = CK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int READ_WAIT_CK   = 2;
    // controller register offsets and fields
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CTRL   = 4'h8;
    localparam int CMD_READ_BIT  = 16;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_REFUSE_BIT = 1;
    localparam int ST_MASK_BIT   = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // controller sequencer
    typedef enum logic [3:0] {
        CS_IDLE = 4'b0001,
        CS_WAKE = 4'b0010,
        CS_CMD  = 4'b0100,
        CS_WAIT = 4'b1000
    } dftm_ctl_state_t;
endpackage : dftm_pkg

// ---- verilog/dftm_link_if.sv ----
/*
 * link between controller and dram mode register logic
 * assumes both ends run on the same system clock; ck is a link signal
 */
`timescale 1ns/1ps
interface dftm_link_if;
    logic       ck;
    logic       cke;
    logic       cs;
    logic       mrw;
    logic [5:0] ma;
    logic [7:0] op;
    logic [5:0] ca;
    logic [7:0] dq_o;
    logic       dq_oe;

    modport ctrl (output ck, cke, cs, mrw, ma, op, ca, input dq_o, dq_oe);
    modport dram (input ck, cke, cs, mrw, ma, op, ca, output dq_o, dq_oe);
endinterface : dftm_link_if

// ---- verilog/dftm_sync.sv ----
/*
 * three-stage input synchroniser with agreement filter
 * assumes inputs asynchronous to clk
 */
`timescale 1ns/1ps
module dftm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // raw and filtered level
    input  wire logic [W-1:0] din,
    output      logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } dftm_sync_state_t;

    dftm_sync_state_t s;
    dftm_sync_state_t next_s;

    // shift and accept where stages two and three agree
    always_comb begin
        next_s    = s;
        next_s.s1 = din;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < W; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.lvl[i] = s.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.lvl;
endmodule : dftm_sync

// ---- verilog/dftm_dram.sv ----
/*
 * dram end: training control and dq reference registers
 * with two set-point copies, answering mode register commands
 * assumes the controller holds link signals stable around ck rise
 */
`timescale 1ns/1ps
module dftm_dram
    import dftm_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // link to controller
    dftm_link_if.dram       link,
    // device feature and raw refresh rate
    input  wire logic       feature_rro,
    input  wire logic [2:0] raw_refresh_rate,
    // training and mode controls
    output      logic       command_bus_training,
    output      logic       read_preamble_training,
    output      logic       reference_output,
    output      logic       fast_reference_current,
    output      logic       mask_enable,
    output      logic       write_setpoint_select,
    output      logic       operating_setpoint_select,
    // active reference setting
    output      logic [5:0] active_dq_code,
    output      logic       active_dq_range,
    // refresh rate report
    output      logic [2:0] refresh_rate_report
);
    localparam int LW = 24;

    typedef struct packed {
        logic [7:0]      ctl;
        logic [1:0][6:0] copy;
        logic            rd_hold;
        logic [6:0]      rd_data;
        logic [7:0]      dq_o;
        logic            dq_oe;
        logic            ck_prev;
        logic [2:0]      rr;
    } dftm_dram_state_t;

    dftm_dram_state_t s;
    dftm_dram_state_t next_s;

    logic [LW-1:0] raw;
    logic [LW-1:0] lvl;
    logic          ck_l;
    logic          cke_l;
    logic          cs_l;
    logic          mrw_l;
    logic [5:0]    ma_l;
    logic [7:0]    op_l;
    logic [5:0]    ca_l;
    logic          ck_rise;
    logic          train_quiet;

    // all link inputs come from outside the clock domain
    assign raw = {link.ck, link.cke, link.cs, link.mrw,
                  link.ma, link.op, link.ca};

    dftm_sync #(
        .W (LW)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (raw),
        .dout  (lvl)
    );

    // split the filtered link bundle
    assign {ck_l, cke_l, cs_l, mrw_l, ma_l, op_l, ca_l} = lvl;
    assign ck_rise   = ck_l & ~s.ck_prev;
    assign train_quiet = s.ctl[BIT_TRAIN] & ~cke_l;

    // refresh report masking
    function automatic logic [2:0] rr_map(
        input logic [2:0] raw_rr,
        input logic       feat,
        input logic       refresh_rate_option
    );
        rr_map = raw_rr;
        // self refresh never depends on the option
        if (feat && !refresh_rate_option) begin
            if (raw_rr == RR_CODE_A || raw_rr == RR_CODE_B) begin
                rr_map = RR_SUBST;
            end
        end
    endfunction : rr_map

    // command decode and dq drive
    always_comb begin
        next_s         = s;
        next_s.ck_prev = ck_l;
        next_s.rr      = rr_map(raw_refresh_rate, feature_rro,
                                s.ctl[BIT_RATEOPT]);
        // commands ignored while training with cke low
        if (ck_rise && cs_l && !train_quiet) begin
            next_s.rd_hold = 1'b0;
            if (mrw_l) begin
                if (ma_l == MA_CTL) begin
                    // write-only, taken unless training with cke low
                    next_s.ctl = op_l;
                end else if (ma_l == MA_DQREF) begin
                    // reserved codes are dropped
                    if (op_l[5:0] <= DQ_CODE_MAX) begin
                        // code and range land in write copy
                        next_s.copy[s.ctl[BIT_WRSEL]] = op_l[6:0];
                    end
                end
            end else if (ma_l == MA_DQREF) begin
                // read reaches the write-selected copy
                next_s.rd_hold = 1'b1;
                next_s.rd_data = s.copy[s.ctl[BIT_WRSEL]];
            end
        end
        // dq priority: training echo, read data, reference out
        if (train_quiet) begin
            next_s.dq_o  = {2'h0, ca_l};
            next_s.dq_oe = 1'b1;
        end else if (next_s.rd_hold) begin
            next_s.dq_o  = {1'b0, next_s.rd_data};
            next_s.dq_oe = 1'b1;
        end else if (next_s.ctl[BIT_REFOUT]) begin
            // only the operating copy is shown
            next_s.dq_o  = {1'b0, next_s.copy[next_s.ctl[BIT_OPSEL]]};
            next_s.dq_oe = 1'b1;
        end else begin
            next_s.dq_o  = 8'h00;
            next_s.dq_oe = 1'b0;
        end
    end

    // state register; copies only change by write or reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s.ctl     <= CTL_RESET;
            s.copy[0] <= {DQ_RANGE_RESET, DQ_CODE_RESET};
            s.copy[1] <= {DQ_RANGE_RESET, DQ_CODE_RESET};
            s.rd_hold <= 1'b0;
            s.rd_data <= 7'h00;
            s.dq_o    <= 8'h00;
            s.dq_oe   <= 1'b0;
            s.ck_prev <= 1'b0;
            s.rr      <= 3'h0;
        end else begin
            s <= next_s;
        end
    end

    // link outputs
    assign link.dq_o  = s.dq_o;
    assign link.dq_oe = s.dq_oe;

    // mode outputs straight from the control byte, mask_enable inverted
    assign command_bus_training      = s.ctl[BIT_TRAIN];
    assign read_preamble_training    = s.ctl[BIT_PREAMBLE];
    assign reference_output          = s.ctl[BIT_REFOUT];
    assign fast_reference_current    = s.ctl[BIT_FASTREF];
    assign mask_enable               = ~s.ctl[BIT_MASKOFF];
    assign write_setpoint_select     = s.ctl[BIT_WRSEL];
    assign operating_setpoint_select = s.ctl[BIT_OPSEL];

    // operation follows the operating copy only
    assign active_dq_code  = s.copy[s.ctl[BIT_OPSEL]][5:0];
    assign active_dq_range = s.copy[s.ctl[BIT_OPSEL]][BIT_RANGE];

    assign refresh_rate_report = s.rr;
endmodule : dftm_dram

// ---- verilog/dftm_ctrl.sv ----
/*
 * controller end: axi4-lite registers, ck divider, command sequencer
 * assumes a 32-bit axi4-lite master and the dram end on the link
 */
`timescale 1ns/1ps
module dftm_ctrl
    import dftm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // axi4-lite write
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // link to dram
    dftm_link_if.ctrl        link
);
    typedef struct packed {
        logic            aw_got;
        logic [3:0]      awaddr;
        logic            w_got;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
        logic [31:0]     ctrl;
        logic [16:0]     cmd;
        logic            pend;
        logic            refused;
        logic            mask_ok;
        logic [7:0]      rd_byte;
        dftm_ctl_state_t st;
        logic [1:0]      wait_ck;
        logic [7:0]      div;
        logic            ck;
        logic            cke;
        logic            cs;
    } dftm_ctrl_state_t;

    dftm_ctrl_state_t s;
    dftm_ctrl_state_t next_s;
    logic [8:0]       dq_l;
    logic             ck_fall;
    logic [31:0]      status;

    dftm_sync #(
        .W (9)
    ) u_dq_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({link.dq_oe, link.dq_o}),
        .dout  (dq_l)
    );

    // byte-lane merge
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  strb
    );
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge

    assign status = {16'h0000, s.rd_byte, 5'h00, s.mask_ok,
                     s.refused, ~s.st[0] | s.pend};
    assign ck_fall = s.ck && (s.div == 8'(CK_HALF_CYCLES - 1));

    always_comb begin
        next_s = s;
        // free-running ck divider
        if (s.div == 8'(CK_HALF_CYCLES - 1)) begin
            next_s.div = 8'h00;
            next_s.ck  = ~s.ck;
        end else begin
            next_s.div = s.div + 8'h01;
        end
        // write channel, address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.aw_got && s.w_got) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            unique case (s.awaddr)
                REG_CMD: begin
                    if (s.st[0] && !s.pend && s.wstrb[0]) begin
                        next_s.cmd     = s.wdata[16:0];
                        next_s.pend    = 1'b1;
                        next_s.refused = 1'b0;
                    end
                end
                REG_STATUS: begin
                    if (s.wstrb[0] && s.wdata[ST_REFUSE_BIT]) begin
                        next_s.refused = 1'b0;
                    end
                end
                REG_CTRL: next_s.ctrl = merge(s.ctrl, s.wdata, s.wstrb);
                default:  next_s.bresp = RESP_SLVERR;
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CMD:    next_s.rdata = {15'h0000, s.cmd};
                REG_STATUS: next_s.rdata = status;
                REG_CTRL:   next_s.rdata = s.ctrl;
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        // sequencer steps on ck falling edges
        if (ck_fall) begin
            unique case (s.st)
                CS_IDLE: begin
                    next_s.cke = ~s.ctrl[0];
                    if (s.pend) begin
                        next_s.pend = 1'b0;
                        // reserved reference codes are not sent
                        if (!s.cmd[CMD_READ_BIT] && s.cmd[13:8] == MA_DQREF
                            && s.cmd[5:0] > DQ_CODE_MAX) begin
                            next_s.refused = 1'b1;
                        end else begin
                            next_s.cke = 1'b1;
                            next_s.st  = CS_WAKE;
                        end
                    end
                end
                CS_WAKE: begin
                    next_s.cs = 1'b1;
                    next_s.st = CS_CMD;
                    // shadow of mask state for masked writes
                    if (!s.cmd[CMD_READ_BIT] && s.cmd[13:8] == MA_CTL) begin
                        next_s.mask_ok = ~s.cmd[BIT_MASKOFF];
                    end
                end
                CS_CMD: begin
                    next_s.cs      = 1'b0;
                    next_s.wait_ck = 2'(READ_WAIT_CK);
                    next_s.st = s.cmd[CMD_READ_BIT] ? CS_WAIT : CS_IDLE;
                end
                CS_WAIT: begin
                    next_s.wait_ck = s.wait_ck - 2'h1;
                    if (s.wait_ck == 2'h1) begin
                        next_s.rd_byte = dq_l[8] ? dq_l[7:0] : 8'h00;
                        next_s.st      = CS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s         <= '0;
            s.ctrl    <= CTRL_RESET;
            s.mask_ok <= 1'b1;
            s.st      <= CS_IDLE;
            s.cke     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // handshakes
    assign s_axi_awready = ~s.aw_got & ~s.bvalid;
    assign s_axi_wready  = ~s.w_got & ~s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = ~s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

    // link drive; whole byte keeps range with code
    assign link.ck  = s.ck;
    assign link.cke = s.cke;
    assign link.cs  = s.cs;
    assign link.mrw = ~s.cmd[CMD_READ_BIT];
    assign link.ma  = s.cmd[13:8];
    assign link.op  = s.cmd[7:0];
    assign link.ca  = s.ctrl[13:8];
endmodule : dftm_ctrl

// ---- tb/dftm_link_asserts.sv ----
/*
 * link checker: command framing, training echo, reference readout
 * assumes it watches the interface that joins the two design ends
 */
`timescale 1ns/1ps
module dftm_link_asserts
    import dftm_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // link signals
    input wire logic       ck,
    input wire logic       cke,
    input wire logic       cs,
    input wire logic       mrw,
    input wire logic [5:0] ma,
    input wire logic [7:0] op,
    input wire logic [5:0] ca,
    input wire logic [7:0] dq_o,
    input wire logic       dq_oe
);
    logic train_q;
    logic refout_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // shadow of training bits, taken as a control write starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            train_q  <= 1'b0;
            refout_q <= 1'b0;
        end else if ($rose(cs) && mrw && ma == MA_CTL) begin
            train_q  <= op[BIT_TRAIN];
            refout_q <= op[BIT_REFOUT];
        end
    end

    // command frame steps
    sequence s_cmd_start;
        $rose(cs);
    endsequence
    sequence s_cmd_held;
        cs [*8] ##1 !cs;
    endsequence

    a_cs_one_period: assert property (s_cmd_start |-> !ck ##0 s_cmd_held)
        else $error("command select not held one link period");
    a_cke_wake_first: assert property (s_cmd_start |-> cke && $past(cke, 7))
        else $error("command issued without clock enable raised first");
    a_cmd_held_whole: assert property (cs && $past(cs) |-> $stable(op) && $stable(ma))
        else $error("command byte changed during command");
    a_no_reserved_code: assert property ($rose(cs) && mrw && ma == MA_DQREF
        |-> op[5:0] <= DQ_CODE_MAX && !op[7])
        else $error("reserved reference code sent");
    a_read_rfu_zero: assert property (dq_oe |-> !dq_o[7])
        else $error("reserved data bit driven high");
    a_held_code_legal: assert property (dq_oe && !train_q |-> dq_o[5:0] <= DQ_CODE_MAX)
        else $error("reference code on dq out of range");
    a_training_echo: assert property ((train_q && !cke) [*8]
        |-> dq_oe && dq_o == {2'b00, ca})
        else $error("training pattern not echoed");
    a_vref_drives_dq: assert property ((refout_q && !train_q && !cs) [*8] |-> dq_oe)
        else $error("reference output not driven");
endmodule : dftm_link_asserts

// ---- tb/dram_fsp_training_mode_regs_test.sv ----
/*
 * self-checking bench: controller and dram ends joined on one link
 * assumes axi4-lite register map and link timing of the design package
 */
`timescale 1ns/1ps
module dram_fsp_training_mode_regs_test
    import dftm_pkg::*;
();
    logic clk, rst_n, feature_rro, rg, f;
    logic [2:0] raw_refresh_rate, rw;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic command_bus_training, read_preamble_training, reference_output;
    logic fast_reference_current, mask_enable, write_setpoint_select, operating_setpoint_select;
    logic [5:0] active_dq_code, code, ca;
    logic active_dq_range;
    logic [2:0] refresh_rate_report;
    logic [7:0] ctl;
    logic [6:0] cp [2];
    int bad_count, check_count, i;

    dftm_link_if link ();
    dftm_ctrl i_dftm_ctrl (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(link));
    dftm_dram i_dftm_dram (.clk, .rst_n, .link(link), .feature_rro, .raw_refresh_rate,
        .command_bus_training, .read_preamble_training, .reference_output,
        .fast_reference_current, .mask_enable, .write_setpoint_select,
        .operating_setpoint_select, .active_dq_code, .active_dq_range, .refresh_rate_report);
    dftm_link_asserts i_dftm_link_asserts (.clk, .rst_n, .ck(link.ck), .cke(link.cke),
        .cs(link.cs), .mrw(link.mrw), .ma(link.ma), .op(link.op), .ca(link.ca),
        .dq_o(link.dq_o), .dq_oe(link.dq_oe));

    // clock
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : check

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // one axi4-lite write or read, answer in q and r
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        logic pa, pw;
        pa = 1'b1;
        pw = wr;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        while (n < 300) begin
            @(posedge clk);
            n++;
            if (wr && pa && s_axi_awready === 1'b1) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (pw && s_axi_wready === 1'b1) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (!wr && pa && s_axi_arready === 1'b1) begin
                pa = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if ((wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1) begin
                q = s_axi_rdata;
                r = wr ? s_axi_bresp : s_axi_rresp;
                n = 1000;
            end
        end
        if (n < 1000) begin
            bad_count++;
            test_done();
        end
    endtask : axi

    // mode register command, then poll until idle; q holds status
    task automatic mr(input logic [5:0] ma, input logic [7:0] op, input logic rd);
        int n;
        n = 0;
        axi(1'b1, REG_CMD, {15'h0000, rd, 2'h0, ma, op});
        q = 32'h0000_0001;
        while (q[ST_BUSY_BIT] !== 1'b0 && n < 100) begin
            axi(1'b0, REG_STATUS, 32'h0000_0000);
            n++;
        end
        if (n >= 100) begin
            bad_count++;
            test_done();
        end
    endtask : mr

    // control byte as seen on the dram outputs, option bit not visible
    function automatic logic [7:0] view();
        return {operating_setpoint_select, write_setpoint_select, ~mask_enable, 1'b0,
                fast_reference_current, reference_output, read_preamble_training,
                command_bus_training};
    endfunction : view

    // refresh report expected from raw code, feature and option bits
    function automatic logic [2:0] rr_exp(input logic [2:0] raw, input logic ft, input logic o);
        return (ft && !o && (raw == RR_CODE_A || raw == RR_CODE_B)) ? RR_SUBST : raw;
    endfunction : rr_exp

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        test_done();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        feature_rro = 1'b0;
        raw_refresh_rate = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        cp[0] = {DQ_RANGE_RESET, DQ_CODE_RESET};
        cp[1] = {DQ_RANGE_RESET, DQ_CODE_RESET};
        void'($urandom(68139));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(view(), 8'h00);
        check({active_dq_range, active_dq_code}, cp[0]);
        axi(1'b0, REG_STATUS, 32'h0000_0000);
        check(q[ST_MASK_BIT], 1'b1);
        axi(1'b0, 4'hC, 32'h0000_0000);
        check(r, RESP_SLVERR);
        // random control writes, copy writes and read-back
        for (i = 0; i < 8; i++) begin
            ctl = 8'($urandom()) & 8'hFA;
            mr(MA_CTL, ctl, 1'b0);
            check(view(), ctl & 8'hEF);
            check(q[ST_MASK_BIT], !ctl[BIT_MASKOFF]);
            code = (i == 0) ? DQ_CODE_MAX : 6'($urandom_range(50));
            rg = 1'($urandom());
            mr(MA_DQREF, {1'b0, rg, code}, 1'b0);
            cp[ctl[BIT_WRSEL]] = {rg, code};
            mr(MA_DQREF, 8'h00, 1'b1);
            check(q[15:8], {1'b0, cp[ctl[BIT_WRSEL]]});
            check({active_dq_range, active_dq_code}, cp[ctl[BIT_OPSEL]]);
            f = 1'($urandom());
            rw = i[2:0];
            feature_rro <= f;
            raw_refresh_rate <= rw;
            repeat (3) @(posedge clk);
            check(refresh_rate_report, rr_exp(rw, f, ctl[BIT_RATEOPT]));
        end
        // reserved code is refused, old copy kept
        mr(MA_DQREF, 8'h33, 1'b0);
        check(q[ST_REFUSE_BIT], 1'b1);
        mr(MA_DQREF, 8'h00, 1'b1);
        check(q[15:8], {1'b0, cp[ctl[BIT_WRSEL]]});
        // reference output shows the operating copy
        ctl = ctl | 8'h04;
        mr(MA_CTL, ctl, 1'b0);
        repeat (16) @(posedge clk);
        check({link.dq_oe, link.dq_o}, {2'b10, cp[ctl[BIT_OPSEL]]});
        // training with clock enable low echoes the pattern
        ca = 6'($urandom());
        axi(1'b1, REG_CTRL, {18'h00000, ca, 8'h01});
        check(r, RESP_OKAY);
        axi(1'b0, REG_CTRL, 32'h0000_0000);
        check(q, {18'h00000, ca, 8'h01});
        mr(MA_CTL, 8'h01, 1'b0);
        repeat (24) @(posedge clk);
        check(command_bus_training, 1'b1);
        check({link.dq_oe, link.dq_o}, {3'b100, ca});
        mr(MA_CTL, 8'h00, 1'b0);
        check(view(), 8'h00);
        // second reset restores the operating copy
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({active_dq_range, active_dq_code}, {DQ_RANGE_RESET, DQ_CODE_RESET});
        test_done();
    end
endmodule : dram_fsp_training_mode_regs_test
